// [dlsc_pkg.sv]
// Purpose: shared constants and types of the laser status/config bank
// Assumes: one 20 MHz clock, byte-wide register port from the serial core
// Notes:   offsets are the register indices seen by the serial core
package dlsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLOCK_HZ          = 20_000_000;
  // configuration mode timeout, in milliseconds
  localparam int unsigned CFG_TIMEOUT_MS    = 100;
  localparam int unsigned CFG_TIMEOUT_CYC   =
    (CLOCK_HZ / 1000) * CFG_TIMEOUT_MS;
  localparam int unsigned CFG_TIMER_W       = 32;

  ////////////////////////////////////////////////////////////////////////////
  // register indices
  typedef logic [5:0] dlsc_addr_t;
  localparam dlsc_addr_t ADDR_EVT_MAIN      = 6'h00;
  localparam dlsc_addr_t ADDR_EVT_CHAN      = 6'h01;
  localparam dlsc_addr_t ADDR_TEMP          = 6'h02;
  localparam dlsc_addr_t ADDR_CONV1_HI      = 6'h03;
  localparam dlsc_addr_t ADDR_CONV1_LO      = 6'h04;
  localparam dlsc_addr_t ADDR_CONV2_HI      = 6'h05;
  localparam dlsc_addr_t ADDR_CONV2_LO      = 6'h06;
  localparam dlsc_addr_t ADDR_CH1_CTRL      = 6'h10;
  localparam dlsc_addr_t ADDR_CH1_ILIM      = 6'h11;
  localparam dlsc_addr_t ADDR_CH1_RMON      = 6'h12;
  localparam dlsc_addr_t ADDR_CH1_SETUP     = 6'h13;
  localparam dlsc_addr_t ADDR_CH1_REFL      = 6'h14;
  localparam dlsc_addr_t ADDR_CH2_CTRL      = 6'h15;
  localparam dlsc_addr_t ADDR_ANALOG        = 6'h1a;
  localparam dlsc_addr_t ADDR_GENERAL       = 6'h1b;
  localparam dlsc_addr_t ADDR_MODE          = 6'h1c;
  localparam dlsc_addr_t ADDR_RANGE         = 6'h1e;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] CTRL_RST           = 8'h18;
  localparam logic [7:0] ILIM_RST           = 8'hff;
  localparam logic [7:0] RMON_RST           = 8'hff;
  localparam logic [7:0] SETUP_RST          = 8'h30;
  localparam logic [7:0] ZERO_RST           = 8'h00;
  localparam logic [7:0] GENERAL_RST        = 8'h02;
  // flags that must read 1 after start-up: ram init, core supply drop
  localparam logic [7:0] EVT_MAIN_RST       = 8'h03;
  // both laser supply drop flags read 1 after start-up
  localparam logic [7:0] EVT_CHAN_RST       = 8'h88;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned CTRL_CURR_MODE    = 0;
  localparam int unsigned CTRL_SW_DIS       = 3;
  localparam int unsigned CTRL_SRC_LSB      = 5;
  localparam int unsigned SETUP_REF_LSB     = 0;
  localparam int unsigned AN_CMEAS_CH1      = 1;
  localparam int unsigned AN_FSENSE_CH1     = 2;
  localparam int unsigned AN_CMEAS_CH2      = 5;
  localparam int unsigned AN_FSENSE_CH2     = 6;
  localparam int unsigned GEN_MERGE         = 6;
  // status main
  localparam int unsigned EM_RAM_INIT       = 0;
  localparam int unsigned EM_CORE_DROP      = 1;
  localparam int unsigned EM_UNVALID        = 2;
  localparam int unsigned EM_OVERTEMP       = 3;
  localparam int unsigned EM_OVC_CH2        = 4;
  localparam int unsigned EM_OVC_CH1        = 5;
  localparam int unsigned EM_OSC            = 6;
  localparam int unsigned EM_CFG_TIMEOUT    = 7;
  // status per channel
  localparam int unsigned EC_LIVE_CH1       = 0;
  localparam int unsigned EC_SEEN_CH1       = 1;
  localparam int unsigned EC_SAT_CH1        = 2;
  localparam int unsigned EC_LSUP_CH1       = 3;
  localparam int unsigned EC_LIVE_CH2       = 4;
  localparam int unsigned EC_SEEN_CH2       = 5;
  localparam int unsigned EC_SAT_CH2        = 6;
  localparam int unsigned EC_LSUP_CH2       = 7;

  ////////////////////////////////////////////////////////////////////////////
  // modes and codes
  localparam logic [1:0] MODE_OPERATION     = 2'h1;
  localparam logic [1:0] MODE_CONFIG        = 2'h2;
  localparam logic [7:0] ILIM_ZERO          = 8'h00;
  localparam logic       SRC_ON             = 1'b1;

  typedef enum logic [2:0] {
    CONV_OFF,
    CONV_MON_CATHODE,
    CONV_RES_NODE,
    CONV_CURR_SENSE,
    CONV_MAIN_SUPPLY,
    CONV_LASER_SUPPLY,
    CONV_LASER_ANODE
  } dlsc_conv_src_t;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic core_supply_drop;
    logic overtemp;
    logic overcurrent_ch1;
    logic overcurrent_ch2;
    logic osc_fail;
    logic sat_ch1;
    logic sat_ch2;
    logic laser_supply_drop_ch1;
    logic laser_supply_drop_ch2;
    logic supplies_differ;
    logic laser_enable_pin_ch1;
    logic laser_enable_pin_ch2;
  } dlsc_events_t;

  typedef struct packed {
    logic [7:0] temp;
    logic [9:0] conv_result_ch1;
    logic [9:0] conv_result_ch2;
  } dlsc_meas_t;

  typedef struct packed {
    logic [7:0] ch1_ctrl;
    logic [7:0] ch1_ilim;
    logic [7:0] ch1_rmon;
    logic [7:0] ch1_setup;
    logic [7:0] ch1_refl;
    logic [7:0] ch2_ctrl;
    logic [7:0] analog;
    logic [7:0] general;
    logic [7:0] range;
  } dlsc_cfg_t;

  localparam dlsc_cfg_t CFG_RST = '{CTRL_RST, ILIM_RST, RMON_RST,
    SETUP_RST, ZERO_RST, CTRL_RST, ZERO_RST, GENERAL_RST, ZERO_RST};

endpackage

// [dlsc_sync.sv]
// Purpose: two-flop synchroniser for a vector of asynchronous levels
// Assumes: each bit is an independent slow level
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module dlsc_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  // levels
  input  wire logic [WIDTH-1:0] i_async,
  output var  logic [WIDTH-1:0] o_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;   // first stage, read by second only
    logic [WIDTH-1:0] sync;   // second stage
  } dlsc_sync_state_t;

  dlsc_sync_state_t state_q;
  dlsc_sync_state_t state_d;

  // shift one stage each clock
  always_comb begin
    state_d.meta = i_async;
    state_d.sync = state_q.meta;
  end

  // state register
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_sync = state_q.sync;

endmodule
`default_nettype wire

// [dlsc_regs.sv]
// Purpose: status and configuration register bank, dual laser driver
// Assumes: serial core gives one-cycle read/write strobes per byte
// Notes:   read data appear one clock after the read strobe
//
// What this block does
// (RULE1) ram init flag set, cleared on read
// (RULE2) core supply drop latched, clear on read
// (RULE3) unvalidated flag while config altered
// (RULE4) overtemperature latched, cleared on read
// (RULE5) sticky overcurrent flags per channel
// (RULE6) oscillator watchdog flag, clear on read
// (RULE7) config timeout sets flag, lasers off
// (RULE8) live enable pin levels readable
// (RULE9) enable pin seen high latched
// (RULE10) output saturation latched per channel
// (RULE11) ch1 supply drop or supplies differ
// (RULE12) ch2 supply drop or either drop
// (RULE13) converter and temperature readouts
// (RULE14) control bit0 picks current regulation
// (RULE15) software disable blocks enable pin
// (RULE16) offset compensation enable, default on
// (RULE17) converter source field decode
// (RULE18) zero limit disables protection in current
// (RULE19) monitor resistor code, default maximum
// (RULE20) ten bit setpoint over two registers
// (RULE21) two bit saturation threshold field
// (RULE22) two bit output range field
// (RULE23) mode 10 config holds, 01 applies
// (RULE24) clear only what the read returned
// (RULE25) host polls status after start-up
`timescale 1ns/1ps
`default_nettype none
module dlsc_regs #(
  parameter int unsigned CFG_TIMEOUT_CYCLES = dlsc_pkg::CFG_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                     i_clock,
  input  wire logic                     i_reset,
  // register port from the serial core
  input  wire dlsc_pkg::dlsc_addr_t     i_reg_addr,
  input  wire logic                     i_reg_rd,
  input  wire logic                     i_reg_wr,
  input  wire logic [7:0]               i_reg_wdata,
  output var  logic [7:0]               o_reg_rdata,
  output var  logic                     o_reg_rvalid,
  // analog events and pins, asynchronous
  input  wire dlsc_pkg::dlsc_events_t   i_evt,
  // measurements, same clock
  input  wire dlsc_pkg::dlsc_meas_t     i_meas,
  // applied configuration and derived controls
  output var  dlsc_pkg::dlsc_cfg_t      o_cfg,
  output var  logic                     o_config_mode,
  output var  logic                     o_laser_en_ch1,
  output var  logic                     o_laser_en_ch2,
  output var  logic                     o_ocp_disable_ch1,
  output var  dlsc_pkg::dlsc_conv_src_t o_conv_src_ch1,
  output var  dlsc_pkg::dlsc_conv_src_t o_conv_src_ch2
);

  import dlsc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    dlsc_cfg_t      cfg;         // written copy
    dlsc_cfg_t      applied;     // copy that drives the analog side
    logic [1:0]     mode;        // operation or configuration
    logic           cfg_mode;    // registered decode of mode
    logic [7:0]     evt_main;    // main status, bit 2 is live
    logic [7:0]     evt_chan;    // channel status, bits 0/4 are live
    logic           unvalid;     // config altered since validation
    logic [CFG_TIMER_W-1:0] timer; // time spent in config mode
    logic           timeout_lock; // lasers held off after timeout
    logic [7:0]     rdata;
    logic           rvalid;
    logic           laser_en_ch1;
    logic           laser_en_ch2;
    logic           ocp_off_ch1;
    dlsc_conv_src_t src_ch1;
    dlsc_conv_src_t src_ch2;
  } dlsc_state_t;

  dlsc_state_t  state_q;
  dlsc_state_t  state_d;
  dlsc_events_t evt_s;           // synchronised events

  ////////////////////////////////////////////////////////////////////////////
  // synchronise every asynchronous event and pin
  dlsc_sync #(
    .WIDTH ($bits(dlsc_events_t))
  ) u_sync (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_async (i_evt),
    .o_sync  (evt_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // converter source decode, one channel
  function automatic dlsc_conv_src_t conv_decode(
    input logic [2:0] code,
    input logic       fsense,
    input logic       cmeas
  );
    dlsc_conv_src_t src;
    src = CONV_OFF;
    // (RULE17) codes 0xx turn converter off
    if (code[2] != SRC_ON) begin
      src = CONV_OFF;
    end else if (code[1:0] == 2'h0) begin
      // current sensor wins over the voltage taps
      if (cmeas) begin
        src = CONV_CURR_SENSE;
      end else if (fsense) begin
        src = CONV_MON_CATHODE;
      end else begin
        src = CONV_RES_NODE;
      end
    end else if (code[1:0] == 2'h1) begin
      src = CONV_MAIN_SUPPLY;
    end else if (code[1:0] == 2'h2) begin
      src = CONV_LASER_SUPPLY;
    end else begin
      src = CONV_LASER_ANODE;
    end
    return src;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic       rd_main;      // read of main status this cycle
    logic       rd_chan;      // read of channel status this cycle
    logic       wr_cfg;       // write to a config register
    logic       merge;        // channels merged
    logic [7:0] set_main;     // events setting main flags
    logic [7:0] set_chan;     // events setting channel flags
    logic [7:0] keep_main;    // bits not cleared by this read
    logic [7:0] keep_chan;
    logic [7:0] live_chan;    // unlatched pin view
    logic       cfg_mode;
    logic       expire;
    rd_main   = 1'b0;
    rd_chan   = 1'b0;
    wr_cfg    = 1'b0;
    merge     = state_q.applied.general[GEN_MERGE];
    set_main  = '0;
    set_chan  = '0;
    keep_main = '1;
    keep_chan = '1;
    live_chan = '0;
    cfg_mode  = (state_q.mode == MODE_CONFIG);
    expire    = 1'b0;
    state_d   = state_q;

    // strobes of this cycle
    if (i_reg_rd) begin
      if (i_reg_addr == ADDR_EVT_MAIN) begin
        rd_main = 1'b1;
      end else if (i_reg_addr == ADDR_EVT_CHAN) begin
        rd_chan = 1'b1;
      end
    end

    // (RULE7) config mode timer and lockout
    if (cfg_mode) begin
      if (state_q.timer >= CFG_TIMER_W'(CFG_TIMEOUT_CYCLES - 1)) begin
        expire = !state_q.timeout_lock;
        state_d.timeout_lock = 1'b1;
      end else begin
        state_d.timer = state_q.timer + CFG_TIMER_W'(1);
      end
    end else begin
      // leaving config mode releases the lockout
      state_d.timer        = '0;
      state_d.timeout_lock = 1'b0;
    end

    // event sources of the main status
    // (RULE2) core supply drop
    set_main[EM_CORE_DROP]   = evt_s.core_supply_drop;
    // (RULE4) overtemperature
    set_main[EM_OVERTEMP]    = evt_s.overtemp;
    // (RULE5) per channel overcurrent
    set_main[EM_OVC_CH2]     = evt_s.overcurrent_ch2;
    set_main[EM_OVC_CH1]     = evt_s.overcurrent_ch1;
    // (RULE6) oscillator watchdog
    set_main[EM_OSC]         = evt_s.osc_fail;
    // (RULE7) timeout event
    set_main[EM_CFG_TIMEOUT] = expire;

    // event sources of the channel status
    // (RULE9) enable pins seen high
    set_chan[EC_SEEN_CH1] = evt_s.laser_enable_pin_ch1;
    set_chan[EC_SEEN_CH2] = evt_s.laser_enable_pin_ch2;
    // (RULE10) output saturation
    set_chan[EC_SAT_CH1]  = evt_s.sat_ch1;
    set_chan[EC_SAT_CH2]  = evt_s.sat_ch2;
    // (RULE11) ch1 drop, or supplies differ when merged
    set_chan[EC_LSUP_CH1] = merge ? evt_s.supplies_differ
                                  : evt_s.laser_supply_drop_ch1;
    // (RULE12) ch2 drop, or either drop when merged
    set_chan[EC_LSUP_CH2] = merge ? (evt_s.laser_supply_drop_ch1 |
                                     evt_s.laser_supply_drop_ch2)
                                  : evt_s.laser_supply_drop_ch2;

    // (RULE24) a read clears only what it returned
    if (rd_main) begin
      keep_main = ~state_q.evt_main;
    end
    if (rd_chan) begin
      keep_chan = ~state_q.evt_chan;
    end
    // (RULE1) ram init flag clears like the others
    // sticky flags: a set in the same cycle wins over the clear
    state_d.evt_main = (state_q.evt_main & keep_main) | set_main;
    state_d.evt_chan = (state_q.evt_chan & keep_chan) | set_chan;
    // live bits are not stored in the sticky byte
    state_d.evt_main[EM_UNVALID]  = 1'b0;
    state_d.evt_chan[EC_LIVE_CH1] = 1'b0;
    state_d.evt_chan[EC_LIVE_CH2] = 1'b0;

    // (RULE8) live pin levels at read time
    live_chan[EC_LIVE_CH1] = evt_s.laser_enable_pin_ch1;
    live_chan[EC_LIVE_CH2] = evt_s.laser_enable_pin_ch2;

    // writes; read-only and unmapped addresses ignore them
    if (i_reg_wr) begin
      if (i_reg_addr == ADDR_CH1_CTRL) begin
        // (RULE14) (RULE15) (RULE16) control byte stored whole
        state_d.cfg.ch1_ctrl = i_reg_wdata;
        wr_cfg = 1'b1;
      end else if (i_reg_addr == ADDR_CH1_ILIM) begin
        // (RULE18) overcurrent limit code
        state_d.cfg.ch1_ilim = i_reg_wdata;
        wr_cfg = 1'b1;
      end else if (i_reg_addr == ADDR_CH1_RMON) begin
        // (RULE19) monitor resistor code
        state_d.cfg.ch1_rmon = i_reg_wdata;
        wr_cfg = 1'b1;
      end else if (i_reg_addr == ADDR_CH1_SETUP) begin
        // (RULE20) (RULE21) setpoint high bits and threshold
        state_d.cfg.ch1_setup = i_reg_wdata;
        wr_cfg = 1'b1;
      end else if (i_reg_addr == ADDR_CH1_REFL) begin
        // (RULE20) setpoint low byte
        state_d.cfg.ch1_refl = i_reg_wdata;
        wr_cfg = 1'b1;
      end else if (i_reg_addr == ADDR_CH2_CTRL) begin
        state_d.cfg.ch2_ctrl = i_reg_wdata;
        wr_cfg = 1'b1;
      end else if (i_reg_addr == ADDR_ANALOG) begin
        state_d.cfg.analog = i_reg_wdata;
        wr_cfg = 1'b1;
      end else if (i_reg_addr == ADDR_GENERAL) begin
        state_d.cfg.general = i_reg_wdata;
        wr_cfg = 1'b1;
      end else if (i_reg_addr == ADDR_RANGE) begin
        // (RULE22) output range fields
        state_d.cfg.range = i_reg_wdata;
        wr_cfg = 1'b1;
      end else if (i_reg_addr == ADDR_MODE) begin
        // (RULE23) only codes 01 and 10 are taken
        if (i_reg_wdata[1:0] == MODE_OPERATION ||
            i_reg_wdata[1:0] == MODE_CONFIG) begin
          state_d.mode = i_reg_wdata[1:0];
        end
      end
    end

    // (RULE3) altered content is unvalidated until mode 01 is written
    if (wr_cfg) begin
      state_d.unvalid = 1'b1;
    end else if (i_reg_wr && i_reg_addr == ADDR_MODE &&
                 i_reg_wdata[1:0] == MODE_OPERATION) begin
      state_d.unvalid = 1'b0;
    end

    // (RULE23) operation mode is transparent, config mode holds
    if (state_d.mode == MODE_OPERATION) begin
      state_d.applied = state_d.cfg;
    end
    // decoded ahead so the mode output leaves a flop directly
    state_d.cfg_mode = (state_d.mode == MODE_CONFIG);

    // (RULE15) (RULE7) pin enables unless disabled or timed out
    state_d.laser_en_ch1 = evt_s.laser_enable_pin_ch1 &
                           !state_q.applied.ch1_ctrl[CTRL_SW_DIS] &
                           !state_d.timeout_lock;
    state_d.laser_en_ch2 = evt_s.laser_enable_pin_ch2 &
                           !state_q.applied.ch2_ctrl[CTRL_SW_DIS] &
                           !state_d.timeout_lock;
    // (RULE18) zero limit in current regulation: no protection
    state_d.ocp_off_ch1 = state_q.applied.ch1_ctrl[CTRL_CURR_MODE] &&
                          (state_q.applied.ch1_ilim == ILIM_ZERO);
    // (RULE17) converter sources from the applied copy
    state_d.src_ch1 = conv_decode(
      state_q.applied.ch1_ctrl[CTRL_SRC_LSB +: 3],
      state_q.applied.analog[AN_FSENSE_CH1],
      state_q.applied.analog[AN_CMEAS_CH1]);
    state_d.src_ch2 = conv_decode(
      state_q.applied.ch2_ctrl[CTRL_SRC_LSB +: 3],
      state_q.applied.analog[AN_FSENSE_CH2],
      state_q.applied.analog[AN_CMEAS_CH2]);

    // read data, registered; unmapped reads return zero
    state_d.rvalid = i_reg_rd;
    state_d.rdata  = '0;
    if (i_reg_rd) begin
      if (i_reg_addr == ADDR_EVT_MAIN) begin
        state_d.rdata = state_q.evt_main;
        // (RULE3) live unvalidated bit
        state_d.rdata[EM_UNVALID] = state_q.unvalid;
      end else if (i_reg_addr == ADDR_EVT_CHAN) begin
        state_d.rdata = state_q.evt_chan | live_chan;
      end else if (i_reg_addr == ADDR_TEMP) begin
        // (RULE13) temperature and converter readouts
        state_d.rdata = i_meas.temp;
      end else if (i_reg_addr == ADDR_CONV1_HI) begin
        state_d.rdata = {6'h00, i_meas.conv_result_ch1[9:8]};
      end else if (i_reg_addr == ADDR_CONV1_LO) begin
        state_d.rdata = i_meas.conv_result_ch1[7:0];
      end else if (i_reg_addr == ADDR_CONV2_HI) begin
        state_d.rdata = {6'h00, i_meas.conv_result_ch2[9:8]};
      end else if (i_reg_addr == ADDR_CONV2_LO) begin
        state_d.rdata = i_meas.conv_result_ch2[7:0];
      end else if (i_reg_addr == ADDR_CH1_CTRL) begin
        state_d.rdata = state_q.cfg.ch1_ctrl;
      end else if (i_reg_addr == ADDR_CH1_ILIM) begin
        state_d.rdata = state_q.cfg.ch1_ilim;
      end else if (i_reg_addr == ADDR_CH1_RMON) begin
        state_d.rdata = state_q.cfg.ch1_rmon;
      end else if (i_reg_addr == ADDR_CH1_SETUP) begin
        state_d.rdata = state_q.cfg.ch1_setup;
      end else if (i_reg_addr == ADDR_CH1_REFL) begin
        state_d.rdata = state_q.cfg.ch1_refl;
      end else if (i_reg_addr == ADDR_CH2_CTRL) begin
        state_d.rdata = state_q.cfg.ch2_ctrl;
      end else if (i_reg_addr == ADDR_ANALOG) begin
        state_d.rdata = state_q.cfg.analog;
      end else if (i_reg_addr == ADDR_GENERAL) begin
        state_d.rdata = state_q.cfg.general;
      end else if (i_reg_addr == ADDR_MODE) begin
        state_d.rdata = {6'h00, state_q.mode};
      end else if (i_reg_addr == ADDR_RANGE) begin
        state_d.rdata = state_q.cfg.range;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; flags that must show after start-up reset to 1
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state_q              <= '0;
      state_q.cfg          <= CFG_RST;
      state_q.applied      <= CFG_RST;
      state_q.mode         <= MODE_OPERATION;
      // (RULE1) memory comes up initialised
      state_q.evt_main     <= EVT_MAIN_RST;
      state_q.evt_chan     <= EVT_CHAN_RST;
      state_q.src_ch1      <= CONV_OFF;
      state_q.src_ch2      <= CONV_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign o_reg_rdata       = state_q.rdata;
  assign o_reg_rvalid      = state_q.rvalid;
  assign o_cfg             = state_q.applied;
  assign o_config_mode     = state_q.cfg_mode;
  assign o_laser_en_ch1    = state_q.laser_en_ch1;
  assign o_laser_en_ch2    = state_q.laser_en_ch2;
  assign o_ocp_disable_ch1 = state_q.ocp_off_ch1;
  assign o_conv_src_ch1    = state_q.src_ch1;
  assign o_conv_src_ch2    = state_q.src_ch2;

endmodule
`default_nettype wire

// [dlsc_regs_chk.sv]
// Purpose: port checker for the status and configuration bank
// Assumes: one clock, asynchronous active high reset
// Notes:   bound to every dlsc_regs instance
`timescale 1ns/1ps
`default_nettype none
module dlsc_regs_chk
  import dlsc_pkg::*;
(
  // watched ports
  input wire logic                 i_clock,
  input wire logic                 i_reset,
  input wire dlsc_pkg::dlsc_addr_t i_reg_addr,
  input wire logic                 i_reg_rd,
  input wire logic                 i_reg_wr,
  input wire logic [7:0]           i_reg_wdata,
  input wire logic [7:0]           o_reg_rdata,
  input wire logic                 o_reg_rvalid,
  input wire dlsc_pkg::dlsc_meas_t i_meas,
  input wire dlsc_pkg::dlsc_cfg_t  o_cfg,
  input wire logic                 o_config_mode,
  input wire logic                 o_laser_en_ch1
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  AST_RD_ANSWER: assert property (i_reg_rd |=> o_reg_rvalid)
    else $error("read strobe not answered");
  AST_RD_QUIET: assert property (!i_reg_rd |=> !o_reg_rvalid && o_reg_rdata == 8'h00)
    else $error("read data outside a read");
  AST_TEMP: assert property (i_reg_rd && i_reg_addr == ADDR_TEMP |=> o_reg_rdata == $past(i_meas.temp))
    else $error("temperature readout wrong");
  AST_CONV_HI: assert property (i_reg_rd && i_reg_addr == ADDR_CONV1_HI |=> o_reg_rdata == {6'h00, $past(i_meas.conv_result_ch1[9:8])})
    else $error("converter high byte wrong");
  AST_ILIM_RD: assert property (i_reg_rd && i_reg_addr == ADDR_CH1_ILIM && !o_config_mode |=> o_reg_rdata == $past(o_cfg.ch1_ilim))
    else $error("limit readback differs from applied");
  AST_MODE_CFG: assert property (i_reg_wr && i_reg_addr == ADDR_MODE && i_reg_wdata[1:0] == MODE_CONFIG |-> ##[1:2] o_config_mode)
    else $error("configuration mode not entered");
  AST_FROZEN: assert property (i_reg_wr && i_reg_addr == ADDR_CH1_CTRL && o_config_mode |=> $stable(o_cfg))
    else $error("applied config moved in config mode");
  AST_SW_DIS: assert property (o_laser_en_ch1 |-> !$past(o_cfg.ch1_ctrl[CTRL_SW_DIS]))
    else $error("laser on while software disabled");
endmodule
bind dlsc_regs dlsc_regs_chk u_chk (.*);
`default_nettype wire

// [dlsc_host.sv]
// Purpose: host model driving the register port
// Assumes: each call starts just after a falling edge
// Notes:   a strobe stays up until the next call changes it
`timescale 1ns/1ps
`default_nettype none
module dlsc_host
  import dlsc_pkg::*;
(
  // register port towards the bank
  input  wire logic                 i_clock,
  output var  dlsc_pkg::dlsc_addr_t o_reg_addr,
  output var  logic                 o_reg_rd,
  output var  logic                 o_reg_wr,
  output var  logic [7:0]           o_reg_wdata
);
  // one port cycle; read data are settled when it returns
  task automatic go(input logic r, w, input dlsc_addr_t a,
    input logic [7:0] d);
    o_reg_rd = r;
    o_reg_wr = w;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(negedge i_clock);
  endtask
  // idle port from time zero
  initial go(1'b0, 1'b0, 6'h00, 8'h00);
endmodule
`default_nettype wire

// [dlsc_regs_tb.sv]
// Purpose: self-checking bench for the status and configuration bank
// Assumes: config timeout shortened to 20 cycles
// Notes:   register table first, then events and modes
`timescale 1ns/1ps
`default_nettype none
module dlsc_regs_tb;
  import dlsc_pkg::*;
  logic           i_clock = 1'b0;
  logic           i_reset = 1'b1;
  dlsc_addr_t     addr;
  logic           rd, wr, rvalid, cmode, en1, en2, ocp1;
  logic [7:0]     wdata, rdata;
  dlsc_events_t   evt = '0;
  dlsc_meas_t     meas = '0;
  dlsc_cfg_t      cfg;
  dlsc_conv_src_t src1, src2;
  int             bad_count = 0;
  int             num_checks = 0;
  // rows: index, reset value, value written
  logic [23:0]    rows [10] = '{24'h101881, 24'h11ff00, 24'h12ff5a,
    24'h13304f, 24'h1400a5, 24'h1518e0, 24'h1a000f, 24'h1b027f,
    24'h1c0101, 24'h1e0031};
  initial forever #25 i_clock = ~i_clock;
  dlsc_regs #(.CFG_TIMEOUT_CYCLES(20)) uut (.i_clock(i_clock),
    .i_reset(i_reset), .i_reg_addr(addr), .i_reg_rd(rd), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_evt(evt), .i_meas(meas), .o_cfg(cfg), .o_config_mode(cmode),
    .o_laser_en_ch1(en1), .o_laser_en_ch2(en2), .o_ocp_disable_ch1(ocp1),
    .o_conv_src_ch1(src1), .o_conv_src_ch2(src2));
  dlsc_host host (.i_clock(i_clock), .o_reg_addr(addr), .o_reg_rd(rd),
    .o_reg_wr(wr), .o_reg_wdata(wdata));
  // compare one value and count it
  task automatic chk(input string nm, input logic [7:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // read one register; answer comes exactly one cycle later
  task automatic rchk(input dlsc_addr_t a, input logic [7:0] e);
    host.go(1'b1, 1'b0, a, ~wdata);
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk("rdata", e, rdata);
  endtask
  // verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge i_clock);
    i_reset = 1'b0;
    // reset value, write, readback for every stored register
    foreach (rows[k]) begin
      rchk(rows[k][21:16], rows[k][15:8]);
      host.go(1'b0, 1'b1, rows[k][21:16], rows[k][7:0]);
      rchk(rows[k][21:16], rows[k][7:0]);
    end
    chk("ocp1", 8'h01, {7'h00, ocp1});
    chk("src2", {5'h00, CONV_LASER_ANODE}, {5'h00, src2});
    chk("src1", {5'h00, CONV_CURR_SENSE}, {5'h00, src1});
    // start-up flags, then validation by mode 01
    rchk(ADDR_EVT_MAIN, 8'h07);
    rchk(ADDR_EVT_MAIN, 8'h04);
    rchk(ADDR_EVT_CHAN, 8'h88);
    rchk(ADDR_EVT_CHAN, 8'h00);
    host.go(1'b0, 1'b1, ADDR_MODE, 8'h01);
    rchk(ADDR_EVT_MAIN, 8'h00);
    // short event bursts, both pins left high
    evt = 12'h7f2;
    repeat (4) host.go(1'b0, 1'b0, ADDR_TEMP, 8'h3c);
    evt = 12'h003;
    repeat (3) host.go(1'b0, 1'b0, ADDR_TEMP, 8'hc3);
    rchk(ADDR_EVT_MAIN, 8'h78);
    rchk(ADDR_EVT_MAIN, 8'h00);
    rchk(ADDR_EVT_CHAN, 8'hf7);
    rchk(ADDR_EVT_CHAN, 8'h33);
    chk("en1", 8'h01, {7'h00, en1});
    chk("en2", 8'h01, {7'h00, en2});
    meas = {8'hff, 10'h3ff, 10'h155};
    rchk(ADDR_TEMP, 8'hff);
    rchk(ADDR_CONV1_HI, 8'h03);
    rchk(ADDR_CONV2_LO, 8'h55);
    // config mode, refused mode code, frozen write, timeout
    host.go(1'b0, 1'b1, ADDR_MODE, 8'h02);
    host.go(1'b0, 1'b1, ADDR_MODE, 8'h03);
    host.go(1'b0, 1'b1, ADDR_CH1_CTRL, 8'h09);
    rchk(ADDR_MODE, 8'h02);
    chk("cmode", 8'h01, {7'h00, cmode});
    chk("cfg", 8'h81, cfg.ch1_ctrl);
    repeat (24) host.go(1'b0, 1'b0, ADDR_TEMP, 8'h5a);
    chk("en1", 8'h00, {7'h00, en1});
    chk("en2", 8'h00, {7'h00, en2});
    rchk(ADDR_EVT_MAIN, 8'h84);
    rchk(6'h08, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
